// File: taer_pkg.sv
// Notes on behaviour
// - Alert has interrupt, comparator, critical-only behaviours.
// - Interrupt alert holds until event clear written.
// - Below limits, mode select bit picks behaviour.
// - Comparator alert follows out-of-limit condition.
// - Critical alert holds until below limit minus hysteresis.
// - All comparisons use programmed hysteresis; the code applies it only to falling-temperature comparisons.
// - Window entry and exit both trigger alert.
// - Reset: monitoring, pointer zero, limits zero, comparator.
// - Interface resets when clock low past timeout.
// - Host keeps serial clock above timeout rate.
// - Write-only pointer selects register, defaults capability.
// - Write-only reads zero; read-only writes ignored.
// - Host avoids writing reserved locations.
// - Capability reads fixed value, upper byte zero.
// - Shutdown releases alert; exit resumes immediately.
// - Status bit cleared in shutdown, resumes after.
// - Resolution field reports eighth-degree steps.
// - Negative temperatures carry sign bit.
// - Host programs limits and configuration first.
// - Pointed registers are sixteen bits wide.
// - Sensor accesses need device type code 0011.
// - Hysteresis codes: none, 1.5, 3.0, 6.0 degrees.
// - Temperature updated at least eight times per second.
package taer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ            = 20000;
  localparam int unsigned BUS_LOW_TIMEOUT_MS = 25;
  localparam int unsigned BUS_LOW_CYCLES     = BUS_LOW_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned CONV_PERIOD_MS     = 125;
  localparam int unsigned CONV_CYCLES        = CONV_PERIOD_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Sensor register map and layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CAPABILITY  = 8'h00;
  localparam logic [7:0]  REG_CONFIG      = 8'h01;
  localparam logic [7:0]  REG_UPPER       = 8'h02;
  localparam logic [7:0]  REG_LOWER       = 8'h03;
  localparam logic [7:0]  REG_CRITICAL    = 8'h04;
  localparam logic [7:0]  REG_TEMPERATURE = 8'h05;
  localparam logic [7:0]  REG_MAKER       = 8'h06;
  localparam logic [7:0]  REG_PART        = 8'h07;
  localparam logic [7:0]  REG_TIMEOUT     = 8'h22;
  localparam logic [7:0]  POINTER_RESET   = 8'h00;
  localparam logic [15:0] CAPABILITY_VAL  = 16'h00f7;
  localparam logic [15:0] LIMIT_RESET     = 16'h0000;
  localparam logic [15:0] TRIP_MASK       = 16'h1ffc;
  localparam logic [12:0] TEMP_MASK       = 13'h1ffe;
  localparam logic [3:0]  SENSOR_TYPE     = 4'h3;
  localparam int          CFG_MODE        = 0;
  localparam int          CFG_POL         = 1;
  localparam int          CFG_CRIT_ONLY   = 2;
  localparam int          CFG_OUT_EN      = 3;
  localparam int          CFG_STATUS      = 4;
  localparam int          CFG_CLEAR       = 5;
  localparam int          CFG_WIN_LOCK    = 6;
  localparam int          CFG_CRIT_LOCK   = 7;
  localparam int          CFG_SHUTDOWN    = 8;
  localparam int          CFG_HYST_LO     = 9;
  localparam int          TMO_ENABLE      = 0;
  localparam logic [13:0] HYST_1P5        = 14'h0018;
  localparam logic [13:0] HYST_3P0        = 14'h0030;
  localparam logic [13:0] HYST_6P0        = 14'h0060;

  // ----------------------------------------------------------------
  // Host controller registers on AHB-Lite
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD    = 8'h00;
  localparam logic [7:0] HOST_WDATA  = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam int         CMD_GO      = 0;
  localparam int         CMD_WRITE   = 1;
  localparam int         CMD_PTR     = 2;
  localparam int         CMD_HOLD    = 3;
  localparam int         CMD_ADDR_LO = 4;
  localparam int         CMD_PTR_LO  = 16;

  typedef enum logic {TAER_OFF, TAER_BUSY} taer_host_state_t;

endpackage

// File: taer_link_if.sv
interface taer_link_if;
  logic        scl;
  logic        req;
  logic [7:0]  req_addr;
  logic [7:0]  req_ptr;
  logic        req_ptr_only;
  logic [15:0] req_wdata;
  logic        done;
  logic        acked;
  logic        timed_out;
  logic [15:0] rdata;
  logic        alert_o;
  logic        alert_oe;
  logic        alert_line;

  // Open-drain alert with pull-up: low only while driven low.
  assign alert_line = alert_oe ? 1'b1 : alert_o;

  modport dev (
    input  scl,
    input  req,
    input  req_addr,
    input  req_ptr,
    input  req_ptr_only,
    input  req_wdata,
    output done,
    output acked,
    output timed_out,
    output rdata,
    output alert_o,
    output alert_oe
  );

  modport host (
    output scl,
    output req,
    output req_addr,
    output req_ptr,
    output req_ptr_only,
    output req_wdata,
    input  done,
    input  acked,
    input  timed_out,
    input  rdata,
    input  alert_line
  );
endinterface

// File: taer_device.sv
module taer_device #(
  parameter int unsigned TIMEOUT_CYCLES = taer_pkg::BUS_LOW_CYCLES,
  parameter int unsigned CONV_CYCLES    = taer_pkg::CONV_CYCLES,
  parameter logic [15:0] MAKER_ID       = 16'h0a5a,  // Arbitrary value.
  parameter logic [15:0] PART_ID        = 16'h0c01   // Arbitrary value.
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  taer_link_if.dev   link,
  input  wire logic  [2:0]  strap_addr,
  input  wire logic  [12:0] temp_sample,
  input  wire logic  temp_sample_valid,
  output logic       conv_start
);
  import taer_pkg::*;

  typedef struct packed {
    logic        scl_m;
    logic        scl_s;
    logic        req_m;
    logic        req_s;
    logic [7:0]  ptr;
    logic        evt_mode;
    logic        evt_pol;
    logic        crit_only;
    logic        out_en;
    logic        win_lock;
    logic        crit_lock;
    logic        shutdown;
    logic [1:0]  hyst;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic [12:0] temp;
    logic        above_up;
    logic        below_lo;
    logic        above_crit;
    logic        evt_latch;
    logic        tmo_en;
    logic [19:0] tmo_cnt;
    logic [21:0] conv_cnt;
    logic        conv_start;
    logic        seen;
    logic        done;
    logic        acked;
    logic        timed_out;
    logic [15:0] rdata;
    logic        alert_o;
    logic        alert_oe;
  } taer_dev_state_t;

  taer_dev_state_t st_ff;
  taer_dev_state_t nxt_st;

  logic signed [13:0] t_s;
  logic signed [13:0] up_s;
  logic signed [13:0] lo_s;
  logic signed [13:0] cr_s;
  logic signed [13:0] hyst_s;
  logic               active;
  logic               drive_low;
  logic               hit;
  logic               wr;
  logic               aligned;
  logic [15:0]        cfg_rd;

  // ----------------------------------------------------------------
  // Threshold arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    t_s  = {st_ff.temp[12], st_ff.temp};
    up_s = {st_ff.upper[12], st_ff.upper[12:0]};
    lo_s = {st_ff.lower[12], st_ff.lower[12:0]};
    cr_s = {st_ff.crit[12], st_ff.crit[12:0]};
    case (st_ff.hyst)
      2'b01:   hyst_s = HYST_1P5;
      2'b10:   hyst_s = HYST_3P0;
      2'b11:   hyst_s = HYST_6P0;
      default: hyst_s = 14'h0000;
    endcase
    if (st_ff.crit_only) begin
      active = st_ff.above_crit;
    end else if (st_ff.evt_mode) begin
      active = st_ff.evt_latch | st_ff.above_crit;
    end else begin
      active = st_ff.above_up | st_ff.below_lo | st_ff.above_crit;
    end
    cfg_rd = 16'h0000;
    cfg_rd[CFG_MODE]      = st_ff.evt_mode;
    cfg_rd[CFG_POL]       = st_ff.evt_pol;
    cfg_rd[CFG_CRIT_ONLY] = st_ff.crit_only;
    cfg_rd[CFG_OUT_EN]    = st_ff.out_en;
    cfg_rd[CFG_STATUS]    = active & ~st_ff.shutdown;
    cfg_rd[CFG_WIN_LOCK]  = st_ff.win_lock;
    cfg_rd[CFG_CRIT_LOCK] = st_ff.crit_lock;
    cfg_rd[CFG_SHUTDOWN]  = st_ff.shutdown;
    cfg_rd[CFG_HYST_LO+:2] = st_ff.hyst;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_m = link.scl;
    nxt_st.scl_s = st_ff.scl_m;
    nxt_st.req_m = link.req;
    nxt_st.req_s = st_ff.req_m;
    // The request is delayed as far as the clock synchroniser, so a clock pulled
    // low together with the request is seen before the access can be taken.
    aligned = link.req && st_ff.req_m && st_ff.req_s;
    nxt_st.done = 1'b0;
    nxt_st.conv_start = 1'b0;
    hit = link.req_addr[7:4] == SENSOR_TYPE && link.req_addr[3:1] == strap_addr;
    wr = 1'b0;

    // Conversion pacing; the converter answers with temp_sample_valid.
    if (!st_ff.shutdown) begin
      if (st_ff.conv_cnt >= 22'(CONV_CYCLES - 1)) begin
        nxt_st.conv_cnt = 22'h000000;
        nxt_st.conv_start = 1'b1;
      end else begin
        nxt_st.conv_cnt = st_ff.conv_cnt + 22'h000001;
      end
      if (temp_sample_valid) begin
        nxt_st.temp = temp_sample & TEMP_MASK;
      end
    end

    // Hysteresis only moves the threshold crossed on falling temperature (the lower trip point, the upper and critical release points).
    if (t_s > up_s) begin
      nxt_st.above_up = 1'b1;
    end else if (t_s < up_s - hyst_s) begin
      nxt_st.above_up = 1'b0;
    end
    if (t_s < lo_s - hyst_s) begin
      nxt_st.below_lo = 1'b1;
    end else if (t_s > lo_s) begin
      nxt_st.below_lo = 1'b0;
    end
    if (t_s > cr_s) begin
      nxt_st.above_crit = 1'b1;
    end else if (t_s < cr_s - hyst_s) begin
      nxt_st.above_crit = 1'b0;
    end

    // Link access, taken only while the serial clock is released.
    if (!link.req) begin
      nxt_st.seen = 1'b0;
    end
    if (!st_ff.scl_s && aligned && st_ff.tmo_en && !st_ff.seen) begin
      if (st_ff.tmo_cnt >= 20'(TIMEOUT_CYCLES - 1)) begin
        nxt_st.seen = 1'b1;
        nxt_st.done = 1'b1;
        nxt_st.acked = 1'b0;
        nxt_st.timed_out = 1'b1;
        nxt_st.tmo_cnt = 20'h00000;
      end else begin
        nxt_st.tmo_cnt = st_ff.tmo_cnt + 20'h00001;
      end
    end else begin
      nxt_st.tmo_cnt = 20'h00000;
    end
    if (st_ff.scl_s && aligned && !st_ff.seen) begin
      nxt_st.seen = 1'b1;
      nxt_st.done = 1'b1;
      nxt_st.acked = hit;
      nxt_st.timed_out = 1'b0;
      nxt_st.rdata = 16'h0000;
      if (hit && !link.req_addr[0]) begin
        nxt_st.ptr = link.req_ptr;
        wr = !link.req_ptr_only;
      end else if (hit) begin
        if (st_ff.ptr == REG_CAPABILITY) begin
          nxt_st.rdata = CAPABILITY_VAL;
        end else if (st_ff.ptr == REG_CONFIG) begin
          nxt_st.rdata = cfg_rd;
        end else if (st_ff.ptr == REG_UPPER) begin
          nxt_st.rdata = st_ff.upper;
        end else if (st_ff.ptr == REG_LOWER) begin
          nxt_st.rdata = st_ff.lower;
        end else if (st_ff.ptr == REG_CRITICAL) begin
          nxt_st.rdata = st_ff.crit;
        end else if (st_ff.ptr == REG_TEMPERATURE) begin
          nxt_st.rdata = {st_ff.above_crit, st_ff.above_up, st_ff.below_lo, st_ff.temp};
        end else if (st_ff.ptr == REG_MAKER) begin
          nxt_st.rdata = MAKER_ID;
        end else if (st_ff.ptr == REG_PART) begin
          nxt_st.rdata = PART_ID;
        end else if (st_ff.ptr == REG_TIMEOUT) begin
          nxt_st.rdata = {15'h0000, st_ff.tmo_en};
        end
      end
    end

    // Register writes; read-only and reserved targets keep their contents.
    if (wr) begin
      if (link.req_ptr == REG_CONFIG) begin
        nxt_st.evt_mode  = link.req_wdata[CFG_MODE];
        nxt_st.evt_pol   = link.req_wdata[CFG_POL];
        nxt_st.crit_only = link.req_wdata[CFG_CRIT_ONLY];
        nxt_st.out_en    = link.req_wdata[CFG_OUT_EN];
        nxt_st.win_lock  = link.req_wdata[CFG_WIN_LOCK];
        nxt_st.crit_lock = st_ff.crit_lock | link.req_wdata[CFG_CRIT_LOCK];
        nxt_st.hyst      = link.req_wdata[CFG_HYST_LO+:2];
        if (!st_ff.win_lock && !st_ff.crit_lock) begin
          nxt_st.shutdown = link.req_wdata[CFG_SHUTDOWN];
        end
        if (link.req_wdata[CFG_CLEAR]) begin
          nxt_st.evt_latch = 1'b0;
        end
      end else if (link.req_ptr == REG_UPPER && !st_ff.win_lock) begin
        nxt_st.upper = link.req_wdata & TRIP_MASK;
      end else if (link.req_ptr == REG_LOWER && !st_ff.win_lock) begin
        nxt_st.lower = link.req_wdata & TRIP_MASK;
      end else if (link.req_ptr == REG_CRITICAL && !st_ff.crit_lock) begin
        nxt_st.crit = link.req_wdata & TRIP_MASK;
      end else if (link.req_ptr == REG_TIMEOUT) begin
        nxt_st.tmo_en = link.req_wdata[TMO_ENABLE];
      end
    end

    // A window crossing in either direction sets the latch; set beats clear.
    if (!st_ff.shutdown && ((nxt_st.above_up != st_ff.above_up) ||
        (nxt_st.below_lo != st_ff.below_lo))) begin
      nxt_st.evt_latch = 1'b1;
    end

    // Output stage: polarity picks which level is driven low.
    drive_low = st_ff.evt_pol ? !(st_ff.out_en && active) : (st_ff.out_en && active);
    nxt_st.alert_o  = 1'b0;
    nxt_st.alert_oe = st_ff.shutdown || !drive_low;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{
        ptr: POINTER_RESET, upper: LIMIT_RESET, lower: LIMIT_RESET,
        crit: LIMIT_RESET, rdata: 16'h0000, alert_oe: 1'b1, scl_m: 1'b1,
        scl_s: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.done      = st_ff.done;
  assign link.acked     = st_ff.acked;
  assign link.timed_out = st_ff.timed_out;
  assign link.rdata     = st_ff.rdata;
  assign link.alert_o   = st_ff.alert_o;
  assign link.alert_oe  = st_ff.alert_oe;
  assign conv_start     = st_ff.conv_start;
endmodule

// File: taer_host.sv
module taer_host (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  hsel,
  input  wire logic  [31:0] haddr,
  input  wire logic  [1:0]  htrans,
  input  wire logic  hwrite,
  input  wire logic  [2:0]  hsize,
  input  wire logic  [31:0] hwdata,
  input  wire logic  hready,
  output logic       hreadyout,
  output logic       hresp,
  output logic       [31:0] hrdata,
  taer_link_if.host  link
);
  import taer_pkg::*;

  typedef struct packed {
    taer_host_state_t state;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        hold;
    logic [7:0]  addr;
    logic [7:0]  ptr;
    logic        ptr_only;
    logic [15:0] wdata;
    logic        done;
    logic        acked;
    logic        timed_out;
    logic [15:0] rdata;
    logic        al_m;
    logic        al_s;
    logic [31:0] hrdata;
    logic        req;
    logic        scl;
  } taer_host_regs_t;

  taer_host_regs_t st_ff;
  taer_host_regs_t nxt_st;
  logic            go;

  // ----------------------------------------------------------------
  // Bus slave and link sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.al_m = link.alert_line;
    nxt_st.al_s = st_ff.al_m;
    nxt_st.wr_pend = 1'b0;
    go = 1'b0;
    if (hsel && htrans[1] && hready) begin
      nxt_st.wr_pend = hwrite;
      nxt_st.wr_addr = haddr[7:0];
      nxt_st.hrdata = 32'h00000000;
      if (!hwrite && haddr[7:0] == HOST_WDATA) begin
        nxt_st.hrdata = {16'h0000, st_ff.wdata};
      end else if (!hwrite && haddr[7:0] == HOST_STATUS) begin
        nxt_st.hrdata = {st_ff.rdata, 11'h000, st_ff.al_s, st_ff.timed_out,
                         st_ff.acked, st_ff.done, st_ff.state == TAER_BUSY};
      end
    end
    if (st_ff.wr_pend) begin
      if (st_ff.wr_addr == HOST_CMD) begin
        nxt_st.hold = hwdata[CMD_HOLD];
        go = hwdata[CMD_GO] && st_ff.state == TAER_OFF;
        if (go) begin
          nxt_st.addr = {hwdata[CMD_ADDR_LO+7:CMD_ADDR_LO+1], ~hwdata[CMD_WRITE]};
          nxt_st.ptr = hwdata[CMD_PTR_LO+:8];
          nxt_st.ptr_only = hwdata[CMD_PTR];
        end
      end else if (st_ff.wr_addr == HOST_WDATA) begin
        nxt_st.wdata = hwdata[15:0];
      end
    end
    case (st_ff.state)
      TAER_OFF: begin
        if (go) begin
          nxt_st.state = TAER_BUSY;
          nxt_st.req = 1'b1;
          nxt_st.done = 1'b0;
        end
      end
      default: begin
        if (link.done) begin
          nxt_st.state = TAER_OFF;
          nxt_st.req = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.acked = link.acked;
          nxt_st.timed_out = link.timed_out;
          nxt_st.rdata = link.rdata;
        end
      end
    endcase
    nxt_st.scl = !(nxt_st.hold && nxt_st.state == TAER_BUSY);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{state: TAER_OFF, scl: 1'b1, al_m: 1'b1, al_s: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = st_ff.hrdata;
  assign link.scl          = st_ff.scl;
  assign link.req          = st_ff.req;
  assign link.req_addr     = st_ff.addr;
  assign link.req_ptr      = st_ff.ptr;
  assign link.req_ptr_only = st_ff.ptr_only;
  assign link.req_wdata    = st_ff.wdata;
endmodule

// File: taer_link_assertions.sv
module taer_link_assertions #(
  parameter int unsigned TIMEOUT_CYCLES = 20
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        scl,
  input wire logic        req,
  input wire logic [7:0]  req_addr,
  input wire logic        done,
  input wire logic        acked,
  input wire logic        timed_out,
  input wire logic [15:0] rdata,
  input wire logic        alert_o,
  input wire logic        alert_oe,
  input wire logic        alert_line
);
  import taer_pkg::*;

  // ----------------------------------------------------------------
  // Held-low counter
  // ----------------------------------------------------------------
  // Counts only while a request waits with the clock held low, so a
  // timeout that fires early or very late shows against a fixed figure.
  logic [15:0] low_cnt_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt_ff <= 16'h0000;
    else if (!req || scl) low_cnt_ff <= 16'h0000;
    else low_cnt_ff <= low_cnt_ff + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_reset_release: assert property ($rose(hresetn) |-> alert_oe && !done)
    else $error("outputs not idle after reset");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_has_req: assert property (done |-> $past(req) && req)
    else $error("done without a request");
  a_answer_bound: assert property ($rose(req) && scl && $past(scl) |-> ##[1:3] done)
    else $error("request not answered in time");
  a_result_stands: assert property (!done |-> $stable(rdata) && $stable({acked, timed_out}))
    else $error("result changed without done");
  a_type_refused: assert property (done && req_addr[7:4] != SENSOR_TYPE |-> !acked)
    else $error("foreign type code acknowledged");
  a_tmo_no_ack: assert property (done && timed_out |-> !acked)
    else $error("timed out access acknowledged");
  a_tmo_not_early: assert property (done && timed_out |-> low_cnt_ff >= TIMEOUT_CYCLES)
    else $error("timeout fired early");
  a_tmo_not_late: assert property (req && !scl |-> low_cnt_ff <= TIMEOUT_CYCLES + 6)
    else $error("timeout fired late");
  a_alert_drain: assert property (!alert_o && (alert_oe || !alert_line))
    else $error("alert pin driven high");

  c_timeout: cover property (done && timed_out);
  c_refused: cover property (done && !acked);
  c_alert_set: cover property ($fell(alert_line));
  c_alert_clr: cover property ($rose(alert_line));
endmodule

// File: tb_temp_alert_event_regs.sv
module tb_temp_alert_event_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import taer_pkg::*;

  localparam logic [6:0] A7 = {SENSOR_TYPE, 3'h5};

  logic        hclk, hresetn, hsel, hwrite, hready, hresp, conv_start, temp_sample_valid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [12:0] temp_sample;
  logic [31:0] haddr, hwdata, hrdata, st;
  int          n_fail, checks;

  taer_link_if link_u ();
  taer_host taer_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link_u.host));
  taer_device #(.TIMEOUT_CYCLES(20), .CONV_CYCLES(50)) taer_device_i (.hclk(hclk),
    .hresetn(hresetn), .link(link_u.dev), .strap_addr(3'h5), .temp_sample(temp_sample),
    .temp_sample_valid(temp_sample_valid), .conv_start(conv_start));
  taer_link_assertions #(.TIMEOUT_CYCLES(20)) taer_link_assertions_i (.hclk(hclk),
    .hresetn(hresetn), .scl(link_u.scl), .req(link_u.req), .req_addr(link_u.req_addr),
    .done(link_u.done), .acked(link_u.acked), .timed_out(link_u.timed_out),
    .rdata(link_u.rdata), .alert_o(link_u.alert_o), .alert_oe(link_u.alert_oe),
    .alert_line(link_u.alert_line));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic give_up(input string nm);
    n_fail++;
    $display("unexpected wait on %s expected 1 seen 0", nm);
    end_of_test;
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) give_up("hready");
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
    chk1("hresp", 1'b0, hresp);
  endtask

  // Polls status, since the link answer time depends on the clock line.
  task automatic link_op(input logic [6:0] a7, input logic [3:0] fl, input logic [7:0] ptr,
                         input logic [15:0] wd);
    int n;
    ahb(HOST_WDATA, 1'b1, {16'h0000, wd}, st);
    ahb(HOST_CMD, 1'b1, {8'h00, ptr, 4'h0, a7, 1'b0, fl}, st);
    n = 0;
    do begin
      ahb(HOST_STATUS, 1'b0, 32'h00000000, st);
      n++;
    end while ((st[1] !== 1'b1 || st[0] !== 1'b0) && n < 100);
    if (st[1] !== 1'b1) give_up("link done");
  endtask

  task automatic sens_wr(input logic [7:0] ptr, input logic [15:0] d);
    link_op(A7, 4'h3, ptr, d);
    chk1("write acked", 1'b1, st[2]);
  endtask

  task automatic reg_is(input string nm, input logic [7:0] ptr, input logic [15:0] e);
    link_op(A7, 4'h7, ptr, 16'h0000);
    link_op(A7, 4'h1, 8'h00, 16'h0000);
    chk16(nm, e, st[31:16]);
  endtask

  task automatic temp_line(input logic [12:0] v, input logic e);
    @(posedge hclk);
    temp_sample <= v;
    temp_sample_valid <= 1'b1;
    @(posedge hclk);
    temp_sample_valid <= 1'b0;
    repeat (4) @(posedge hclk);
    chk1("alert_line", e, link_u.alert_line);
  endtask

  task automatic conv_count(input logic [15:0] e);
    int c;
    c = 0;
    repeat (100) begin
      @(posedge hclk);
      if (conv_start === 1'b1) c++;
    end
    chk16("conv_pulses", e, c[15:0]);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    logic [7:0] p [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h22};
    chk1("alert_line", 1'b1, link_u.alert_line);
    link_op(A7, 4'h1, 8'h00, 16'h0000);
    chk16("default pointer", 16'h00f7, st[31:16]);
    foreach (p[i]) reg_is("reset value", p[i], 16'h0000);
    reg_is("reserved", 8'h10, 16'h0000);
    sens_wr(REG_CAPABILITY, 16'hffff);
    reg_is("capability", REG_CAPABILITY, 16'h00f7);
    sens_wr(REG_UPPER, 16'hffff);
    reg_is("upper", REG_UPPER, TRIP_MASK);
    link_op({4'h5, 3'h5}, 4'h1, 8'h00, 16'h0000);
    chk1("bad type acked", 1'b0, st[2]);
    link_op({SENSOR_TYPE, 3'h2}, 4'h1, 8'h00, 16'h0000);
    chk1("bad strap acked", 1'b0, st[2]);
  endtask

  task automatic t_comparator;
    logic [12:0] h [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
    sens_wr(REG_UPPER, 16'h0100);
    sens_wr(REG_LOWER, 16'h1fc0);
    sens_wr(REG_CRITICAL, 16'h0200);
    for (int i = 0; i < 4; i++) begin
      sens_wr(REG_CONFIG, {5'h00, i[1:0], 9'h008});
      temp_line(13'h0080, 1'b1);
      temp_line(13'h0110, 1'b0);
      temp_line(13'h0102 - h[i], 1'b0);
      temp_line(13'h00fe - h[i], 1'b1);
    end
    sens_wr(REG_CONFIG, 16'h0208);
    temp_line(13'h1f80, 1'b0);
    reg_is("temperature", REG_TEMPERATURE, 16'h3f80);
    temp_line(13'h1fb0, 1'b0);
    temp_line(13'h1fd0, 1'b1);
  endtask

  task automatic t_interrupt;
    sens_wr(REG_CONFIG, 16'h0229);
    temp_line(13'h0080, 1'b1);
    temp_line(13'h0110, 1'b0);
    temp_line(13'h0080, 1'b0);
    sens_wr(REG_CONFIG, 16'h0229);
    chk1("alert_line", 1'b1, link_u.alert_line);
    reg_is("config", REG_CONFIG, 16'h0209);
    temp_line(13'h1f80, 1'b0);
    sens_wr(REG_CONFIG, 16'h0229);
    temp_line(13'h0080, 1'b0);
  endtask

  task automatic t_critical;
    sens_wr(REG_CONFIG, 16'h022c);
    temp_line(13'h0110, 1'b1);
    temp_line(13'h0210, 1'b0);
    temp_line(13'h01f0, 1'b0);
    temp_line(13'h01e0, 1'b1);
    sens_wr(REG_CONFIG, 16'h022e);
    temp_line(13'h01e0, 1'b0);
    temp_line(13'h0210, 1'b1);
  endtask

  task automatic t_shutdown;
    sens_wr(REG_CONFIG, 16'h0208);
    temp_line(13'h0110, 1'b0);
    conv_count(16'h0002);
    sens_wr(REG_CONFIG, 16'h0308);
    chk1("alert_line", 1'b1, link_u.alert_line);
    reg_is("config in shutdown", REG_CONFIG, 16'h0308);
    conv_count(16'h0000);
    sens_wr(REG_CONFIG, 16'h0208);
    repeat (4) @(posedge hclk);
    chk1("alert_line", 1'b0, link_u.alert_line);
    ahb(HOST_STATUS, 1'b0, 32'h00000000, st);
    chk1("status alert", 1'b0, st[4]);
    reg_is("config resumed", REG_CONFIG, 16'h0218);
  endtask

  task automatic t_timeout;
    sens_wr(REG_TIMEOUT, 16'h0001);
    reg_is("timeout", REG_TIMEOUT, 16'h0001);
    link_op(A7, 4'h9, 8'h00, 16'h0000);
    chk1("timed out", 1'b1, st[3]);
    chk1("acked", 1'b0, st[2]);
    ahb(HOST_CMD, 1'b1, 32'h00000000, st);
    reg_is("after timeout", REG_TIMEOUT, 16'h0001);
  endtask

  // The critical lock sticks until reset, so this runs last and ends with a reset in mid-run.
  task automatic t_locks;
    sens_wr(REG_CONFIG, 16'h00c8);
    sens_wr(REG_UPPER, 16'h0300);
    sens_wr(REG_CRITICAL, 16'h0300);
    sens_wr(REG_CONFIG, 16'h0188);
    reg_is("locked upper", REG_UPPER, 16'h0100);
    reg_is("locked crit", REG_CRITICAL, 16'h0200);
    reg_is("locked config", REG_CONFIG, 16'h0098);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    reg_is("config after reset", REG_CONFIG, 16'h0000);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    temp_sample = 13'h0080;
    temp_sample_valid = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults;
    t_comparator;
    t_interrupt;
    t_critical;
    t_shutdown;
    t_timeout;
    t_locks;
    end_of_test;
  end
endmodule
